//--- core/cchp_params.svh
// Constants of the CAN controller host port: offsets, field positions, resets
`ifndef CCHP_PARAMS_SVH
`define CCHP_PARAMS_SVH

// ***************************************************************
// Register map
// ***************************************************************
`define CCHP_SETUP_ADDR     8'h10
`define CCHP_ADDR_BITS      8
`define CCHP_DATA_BITS      8

// ***************************************************************
// Setup/status register fields
// ***************************************************************
`define CCHP_INIT_BIT       0
`define CCHP_HOLD_BIT       1
`define CCHP_ADE_BIT        2
`define CCHP_ACTIVE_BIT     7
`define CCHP_SETUP_WR_MASK  8'h07
`define CCHP_SETUP_RST      8'h03

// ***************************************************************
// Serial framing
// ***************************************************************
`define CCHP_LAST_BIT       3'h7

`endif

//--- core/cchp_pkg.sv
// Types shared by the CAN controller host port modules
package cchp_pkg;

   // ************************************************************
   // Host interface mode, fixed by the strap after reset
   // ************************************************************
   typedef enum logic [1:0] {
      CCHP_MODE_PAR = 2'b01,
      CCHP_MODE_SER = 2'b10
   } cchp_mode_e;

   // ************************************************************
   // One finished serial byte, handed from link to core clock
   // ************************************************************
   typedef struct packed {
      logic [7:0] data;
      logic       is_addr;
      logic       is_read;
   } cchp_sev_s;

   // ************************************************************
   // One register access request towards the register memory
   // ************************************************************
   typedef struct packed {
      logic       we;
      logic       re;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cchp_acc_s;

endpackage : cchp_pkg

//--- core/cchp_regmem.sv
// Byte-wide register memory with registered read data
module cchp_regmem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input  wire logic          ref_clk_in,
   input  wire logic          we_in,
   input  wire logic          re_in,
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [DW-1:0] wdata_in,
   output logic      [DW-1:0] rdata_out
);
   logic [DW-1:0] mem_r [0:(1<<AW)-1];

   // Write port; contents are not reset, software initialises them
   always_ff @(posedge ref_clk_in) begin
      if (we_in) begin
         mem_r[addr_in] <= wdata_in;
      end
   end

   // Read data held in a register until the next read
   always_ff @(posedge ref_clk_in) begin
      if (re_in) begin
         rdata_out <= mem_r[addr_in];
      end
   end
endmodule // cchp_regmem

//--- core/cchp_serial_link.sv
// Serial link end of the host port, clocked by the host's serial clock
`include "cchp_params.svh"

module cchp_serial_link (
   input  wire logic              sclk_in,
   input  wire logic              nrst_in,
   input  wire logic              cs_n_in,
   input  wire logic              serial_data_in,
   input  wire logic              direction_in,
   input  wire logic              output_edge_select_in,
   input  wire logic [7:0]        rd_byte_in,
   output logic                   ev_tgl_out,
   output cchp_pkg::cchp_sev_s    ev_out,
   output logic                   serial_data_out
);
   import cchp_pkg::*;

   logic [2:0] bit_cnt_r;
   logic [6:0] shift_r;
   logic       first_r;
   logic [2:0] neg_cnt_r;
   logic       neg_first_r;
   logic       fall_bit;
   logic       out_bit;

   // ************************************************************
   // Framing: the clock stands still between frames, so the frame
   // state is cleared by chip select itself, not by a clock edge
   // ************************************************************
   always_ff @(posedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         bit_cnt_r <= 3'h0;
         first_r   <= 1'b1;
      end else begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (bit_cnt_r == `CCHP_LAST_BIT) begin
            first_r <= 1'b0;
         end
      end
   end

   // Input bits shift in on the rising clock edge, MSB first
   always_ff @(posedge sclk_in) begin
      shift_r <= {shift_r[5:0], serial_data_in};
   end

   // Byte event: bundle first, toggle with it; core samples later
   always_ff @(posedge sclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ev_tgl_out <= 1'b0;
         ev_out     <= '0;
      end else if (!cs_n_in && bit_cnt_r == `CCHP_LAST_BIT) begin
         ev_out.data    <= {shift_r, serial_data_in};
         ev_out.is_addr <= first_r;
         ev_out.is_read <= direction_in;
         ev_tgl_out     <= ~ev_tgl_out;
      end
   end

   // ************************************************************
   // Output side: bit index follows the rising-edge counter
   // ************************************************************
   assign out_bit = (!first_r && direction_in) ?
                    rd_byte_in[~bit_cnt_r] : 1'b0;

   // Falling-edge copy of the frame state, not of the bit: the first
   // bit of a byte is fetched after that edge and must still show
   always_ff @(negedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         neg_cnt_r   <= 3'h0;
         neg_first_r <= 1'b1;
      end else begin
         neg_cnt_r   <= bit_cnt_r;
         neg_first_r <= first_r;
      end
   end

   assign fall_bit = (!neg_first_r && direction_in) ?
                     rd_byte_in[~neg_cnt_r] : 1'b0;

   assign serial_data_out = output_edge_select_in ?
                            fall_bit : out_bit;
endmodule // cchp_serial_link

//--- core/cchp_top.sv
// Host access port of a stand-alone CAN controller: parallel and serial
`include "cchp_params.svh"

module cchp_top (
   input  wire logic        ref_clk_in,
   input  wire logic        nrst_in,
   input  wire logic        interface_select_in,
   input  wire logic        cs_n_in,
   input  wire logic        ale_in,
   input  wire logic        wr_n_in,
   input  wire logic        rd_n_in,
   input  wire logic [7:0]  muxed_bus_lines_in,
   output logic      [7:0]  muxed_bus_lines_out,
   output logic             muxed_bus_lines_oe_n_out,
   input  wire logic        sclk_in,
   input  wire logic        direction_in,
   input  wire logic        serial_data_in,
   input  wire logic        output_edge_select_in,
   output logic             serial_data_out,
   input  wire logic        msg_event_in,
   output logic             irq_n_out,
   output logic             init_mode_bit_out,
   output logic             soft_hold_bit_out,
   output logic             bus_join_out,
   output logic             serial_mode_out
);
   import cchp_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [1:0]  sel_sync_r;
   logic [1:0]  cs_sync_r;
   logic [2:0]  ale_sync_r;
   logic [2:0]  wr_sync_r;
   logic [2:0]  rd_sync_r;
   logic [7:0]  ad_meta_r;
   logic [7:0]  ad_sync_r;
   logic [2:0]  tgl_sync_r;
   cchp_mode_e  mode_r;
   logic        strap_done_r;
   logic [7:0]  setup_r;
   logic [7:0]  par_addr_r;
   logic [7:0]  par_rd_r;
   logic        par_rd_pend_r;
   logic [7:0]  ser_ptr_r;
   logic [7:0]  ser_rd_r;
   logic        ser_rd_pend_r;
   logic        rd_setup_r;
   logic        irq_r;
   cchp_acc_s   acc;
   logic [7:0]  mem_rdata;
   logic [7:0]  rd_value;
   logic        ser_ev_tgl;
   cchp_sev_s   ser_ev;
   cchp_sev_s   ev_r;
   logic        ev_new;
   logic        ev_pend_r;
   logic        ale_fall;
   logic        wr_rise;
   logic        rd_fall;
   logic        par_sel;
   logic [7:0]  ser_next;

   // Decode shared by both host paths and the read-back mux
   function automatic logic hits_setup(input logic [7:0] a);
      return a == `CCHP_SETUP_ADDR;
   endfunction

   // Address step after a data byte; steady when decrement is off
   function automatic logic [7:0] step_addr(input logic [7:0] a,
                                            input logic       ade);
      return ade ? a - 8'h01 : a;
   endfunction

   // ************************************************************
   // Pin synchronisers (two flops before core-clock logic reads the strap or a bus pin)
   // ************************************************************
   // Strap synchroniser runs through reset, so it is full at release
   always_ff @(posedge ref_clk_in) begin
      sel_sync_r <= {sel_sync_r[0], interface_select_in};
   end

   // Bus pins and strobes, held at their idle levels during reset
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         cs_sync_r  <= 2'h3;
         ale_sync_r <= 3'h0;
         wr_sync_r  <= 3'h7;
         rd_sync_r  <= 3'h7;
         ad_meta_r  <= 8'h00;
         ad_sync_r  <= 8'h00;
      end else begin
         cs_sync_r  <= {cs_sync_r[0], cs_n_in};
         ale_sync_r <= {ale_sync_r[1:0], ale_in};
         wr_sync_r  <= {wr_sync_r[1:0], wr_n_in};
         rd_sync_r  <= {rd_sync_r[1:0], rd_n_in};
         ad_meta_r  <= muxed_bus_lines_in;
         ad_sync_r  <= ad_meta_r;
      end
   end

   // Strobe edges are taken from the second and third flops only
   assign ale_fall = ale_sync_r[2] & ~ale_sync_r[1];
   assign wr_rise  = ~wr_sync_r[2] & wr_sync_r[1];
   assign rd_fall  = rd_sync_r[2] & ~rd_sync_r[1];
   assign par_sel  = ~cs_sync_r[1] & (mode_r == CCHP_MODE_PAR);

   // ************************************************************
   // Interface strap, caught once after reset release
   // ************************************************************
   // The strap is sampled after the synchroniser has filled, so a
   // level that settles during reset is seen correctly
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         mode_r       <= CCHP_MODE_PAR;
         strap_done_r <= 1'b0;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         mode_r       <= sel_sync_r[1] ? CCHP_MODE_SER
                                       : CCHP_MODE_PAR;
      end
   end

   assign serial_mode_out = (mode_r == CCHP_MODE_SER);

   // ************************************************************
   // Serial link (runs on the host's serial clock)
   // ************************************************************
   cchp_serial_link u_link (
      .sclk_in               (sclk_in),
      .nrst_in               (nrst_in),
      .cs_n_in               (cs_n_in),
      .serial_data_in        (serial_data_in),
      .direction_in          (direction_in),
      .output_edge_select_in (output_edge_select_in),
      .rd_byte_in            (ser_rd_r),
      .ev_tgl_out            (ser_ev_tgl),
      .ev_out                (ser_ev),
      .serial_data_out       (serial_data_out)
   );

   // Toggle crossing; the byte bundle is stable long before the
   // synchronised toggle shows, so it is sampled on the edge
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         tgl_sync_r <= 3'h0;
         ev_r       <= '0;
         ev_pend_r  <= 1'b0;
      end else begin
         tgl_sync_r <= {tgl_sync_r[1:0], ser_ev_tgl};
         ev_pend_r  <= (tgl_sync_r[2] != tgl_sync_r[1]);
         if (tgl_sync_r[2] != tgl_sync_r[1]) begin
            ev_r <= ser_ev;
         end
      end
   end

   // Request raised one edge late, once the bundle copy is in ev_r
   assign ev_new = ev_pend_r && (mode_r == CCHP_MODE_SER);

   // Next address after a data byte, auto-decrement applied
   assign ser_next = step_addr(ser_ptr_r,
                               setup_r[`CCHP_ADE_BIT]);

   // ************************************************************
   // Access request towards memory and setup register
   // ************************************************************
   // Only the strapped mode issues requests, so the two host
   // paths never compete for the single memory port
   always_comb begin
      acc = '0;
      if (mode_r == CCHP_MODE_PAR) begin
         if (par_sel && wr_rise) begin
            acc.we    = 1'b1;
            acc.addr  = par_addr_r;
            acc.wdata = ad_sync_r;
         end else if (par_sel && rd_fall) begin
            acc.re   = 1'b1;
            acc.addr = par_addr_r;
         end
      end else if (ev_new) begin
         if (ev_r.is_addr) begin
            acc.re   = ev_r.is_read;
            acc.addr = ev_r.data;
         end else if (ev_r.is_read) begin
            acc.re   = 1'b1;
            acc.addr = ser_next;
         end else begin
            acc.we    = 1'b1;
            acc.addr  = ser_ptr_r;
            acc.wdata = ev_r.data;
         end
      end
   end

   cchp_regmem #(
      .AW (`CCHP_ADDR_BITS),
      .DW (`CCHP_DATA_BITS)
   ) u_mem (
      .ref_clk_in (ref_clk_in),
      .we_in      (acc.we && !hits_setup(acc.addr)),
      .re_in      (acc.re),
      .addr_in    (acc.addr),
      .wdata_in   (acc.wdata),
      .rdata_out  (mem_rdata)
   );

   // ************************************************************
   // Parallel path: address latch and read data
   // ************************************************************
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         par_addr_r <= 8'h00;
      end else if (par_sel && ale_fall) begin
         par_addr_r <= ad_sync_r;
      end
   end

   // Read-back mux: setup register overlays its memory location
   assign rd_value = rd_setup_r ?
                     {bus_join_out, setup_r[6:0]} : mem_rdata;

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         rd_setup_r    <= 1'b0;
         par_rd_pend_r <= 1'b0;
         par_rd_r      <= 8'h00;
      end else begin
         rd_setup_r    <= acc.re && hits_setup(acc.addr);
         par_rd_pend_r <= acc.re && (mode_r == CCHP_MODE_PAR);
         if (par_rd_pend_r) begin
            par_rd_r <= rd_value;
         end
      end
   end

   // Bus is driven only while selected and the fetch strobe is low
   assign muxed_bus_lines_out      = par_rd_r;
   assign muxed_bus_lines_oe_n_out = ~(par_sel & ~rd_sync_r[1]);

   // ************************************************************
   // Serial path: address pointer and read byte
   // ************************************************************
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         ser_ptr_r <= 8'h00;
      end else if (ev_new) begin
         if (ev_r.is_addr) begin
            ser_ptr_r <= ev_r.data;
         end else begin
            ser_ptr_r <= ser_next;
         end
      end
   end

   // The read byte stays put until the next request completes; the
   // host must leave a short pause between bytes for it to settle
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         ser_rd_pend_r <= 1'b0;
         ser_rd_r      <= 8'h00;
      end else begin
         ser_rd_pend_r <= acc.re && (mode_r == CCHP_MODE_SER);
         if (ser_rd_pend_r) begin
            ser_rd_r <= rd_value;
         end
      end
   end

   // ************************************************************
   // Setup/status register and initialisation state
   // ************************************************************
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         setup_r <= `CCHP_SETUP_RST;
      end else if (acc.we && hits_setup(acc.addr)) begin
         setup_r <= acc.wdata & `CCHP_SETUP_WR_MASK;
      end
   end

   assign init_mode_bit_out = setup_r[`CCHP_INIT_BIT];
   assign soft_hold_bit_out = setup_r[`CCHP_HOLD_BIT];
   // The protocol engine joins the bus only once both bits are clear
   assign bus_join_out = ~setup_r[`CCHP_INIT_BIT] &
                         ~setup_r[`CCHP_HOLD_BIT];

   // ************************************************************
   // Interrupt line
   // ************************************************************
   // Level from the message engine, registered so the pin is clean
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= msg_event_in;
      end
   end

   assign irq_n_out = ~irq_r;
endmodule // cchp_top

//--- tb/cchp_top_monitor.sv
// Checker of the host port pins, bound to the top module
module cchp_top_monitor (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic interface_select_in,
   input wire logic cs_n_in,
   input wire logic rd_n_in,
   input wire logic sclk_in,
   input wire logic output_edge_select_in,
   input wire logic msg_event_in,
   input wire logic muxed_bus_lines_oe_n_out,
   input wire logic serial_data_out,
   input wire logic irq_n_out,
   input wire logic init_mode_bit_out,
   input wire logic soft_hold_bit_out,
   input wire logic bus_join_out,
   input wire logic serial_mode_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************************
   // Pin relations
   // ************************************************************
   logic rise_val_r;

   // Output level held just before each serial clock rise
   always_ff @(posedge sclk_in) begin
      rise_val_r <= serial_data_out;
   end

   a_mode_from_strap: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      $rose(nrst_in) |-> ##2 serial_mode_out == interface_select_in)
      else $error("Mode does not follow strap");
   a_reset_state: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      $rose(nrst_in) |-> init_mode_bit_out && soft_hold_bit_out
         && !bus_join_out && irq_n_out)
      else $error("Wrong state after reset");
   a_irq_on_event: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      msg_event_in |=> !irq_n_out)
      else $error("Interrupt not raised");
   a_irq_quiet: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      !msg_event_in [*2] |-> irq_n_out)
      else $error("Interrupt without event");
   a_join_when_clear: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (!init_mode_bit_out && !soft_hold_bit_out) [*2] |-> bus_join_out)
      else $error("Bus not joined");
   a_no_join_init: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (init_mode_bit_out || soft_hold_bit_out) [*2] |-> !bus_join_out)
      else $error("Joined during setup");
   a_read_drives_bus: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      $fell(rd_n_in) && !cs_n_in && !serial_mode_out
         |-> ##[1:4] !muxed_bus_lines_oe_n_out)
      else $error("Bus not driven on read");
   a_bus_released: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      rd_n_in [*5] |-> muxed_bus_lines_oe_n_out)
      else $error("Bus driven without read");
   a_serial_no_bus: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      serial_mode_out |-> muxed_bus_lines_oe_n_out)
      else $error("Bus driven in serial mode");
   a_sdo_on_fall: assert property (
      @(negedge sclk_in) disable iff (!nrst_in)
      output_edge_select_in && !cs_n_in |-> serial_data_out == rise_val_r)
      else $error("Serial output moved on rising edge");
endmodule // cchp_top_monitor

//--- tb/cchp_host_model.sv
// Host serial master model: frames, clocks and shifts bytes
module cchp_host_model (
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      direction_out,
   output logic      sdi_out,
   input  wire logic sdo_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************************
   // Serial master
   // ************************************************************
   logic [7:0] frame_data [4]; // Bytes to send, or bytes received

   // Idle: clock stands low, device deselected
   initial begin
      sclk_out      = 1'b0;
      cs_n_out      = 1'b1;
      direction_out = 1'b0;
      sdi_out       = 1'b0;
   end

   // Bit set while clock is low, read data taken just before the rise
   task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sdi_out = tx[i];
         #62.5;
         rx[i]    = sdo_in;
         sclk_out = 1'b1;
         #62.5;
         sclk_out = 1'b0;
      end
      sdi_out = ~tx[0]; // Released line never repeats the last bit
      #1200; // Pause gives the device time to fetch the next byte
   endtask

   // Address byte first, then n data bytes in one select frame
   task automatic frame(input logic rd, input logic [7:0] a, input int n);
      logic [7:0] rx;
      cs_n_out      = 1'b0;
      direction_out = rd;
      #137;
      shift_byte(a, rx);
      for (int k = 0; k < n; k++) begin
         shift_byte(frame_data[k], rx);
         if (rd) begin
            frame_data[k] = rx;
         end
      end
      cs_n_out = 1'b1;
      #250;
   endtask
endmodule // cchp_host_model

//--- tb/cchp_top_bench.sv
// Self-checking bench of the host port in both interface modes
`include "cchp_params.svh"
`define CHK(got, exp) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end

module cchp_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************************
   // Harness
   // ************************************************************
   logic       ref_clk, nrst, strap, par_cs_n, ale, wr_n, rd_n;
   logic       tim, msg_event, oe_n, sdo, irq_n, ser_mode;
   logic       init_bit, hold_bit, join_bit;
   logic [7:0] host_bus, dut_bus, bus_wire, rd_data;
   wire logic  h_sclk, h_cs_n, h_dir, h_sdi;
   int         err_count, total_checks;

   // Shared bus: device wins only while it enables its drivers
   assign bus_wire = oe_n ? host_bus : dut_bus;

   cchp_top dut (
      .ref_clk_in(ref_clk), .nrst_in(nrst), .interface_select_in(strap),
      .cs_n_in(par_cs_n & h_cs_n), .ale_in(ale), .wr_n_in(wr_n),
      .rd_n_in(rd_n), .muxed_bus_lines_in(bus_wire),
      .muxed_bus_lines_out(dut_bus), .muxed_bus_lines_oe_n_out(oe_n),
      .sclk_in(h_sclk), .direction_in(h_dir), .serial_data_in(h_sdi),
      .output_edge_select_in(tim), .serial_data_out(sdo),
      .msg_event_in(msg_event), .irq_n_out(irq_n),
      .init_mode_bit_out(init_bit), .soft_hold_bit_out(hold_bit),
      .bus_join_out(join_bit), .serial_mode_out(ser_mode));

   cchp_host_model host (.sclk_out(h_sclk), .cs_n_out(h_cs_n),
      .direction_out(h_dir), .sdi_out(h_sdi), .sdo_in(sdo));

   // Core clock, 100 ns period
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic wrap_up();
      if (err_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Strap is only taken after a reset, so each mode gets its own
   task automatic do_reset(input logic s);
      @(negedge ref_clk);
      nrst  = 1'b0;
      strap = s;
      repeat (4) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (3) @(negedge ref_clk);
   endtask

   task automatic par_addr(input logic [7:0] a, input logic cs_n);
      @(negedge ref_clk);
      par_cs_n = cs_n;
      ale      = 1'b1;
      host_bus = a;
      repeat (3) @(negedge ref_clk);
      ale = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask

   task automatic par_wr(input logic [7:0] a, d, input logic cs_n);
      par_addr(a, cs_n);
      host_bus = d;
      wr_n     = 1'b0;
      repeat (5) @(negedge ref_clk);
      wr_n = 1'b1;
      repeat (4) @(negedge ref_clk); // Data held past the strobe
      par_cs_n = 1'b1;
      host_bus = ~d;
   endtask

   task automatic par_rd(input logic [7:0] a);
      par_addr(a, 1'b0);
      host_bus = ~a; // Host lets go of the bus
      rd_n     = 1'b0;
      repeat (6) @(negedge ref_clk);
      `CHK(oe_n, 1'b0)
      rd_data = bus_wire;
      rd_n    = 1'b1;
      repeat (4) @(negedge ref_clk);
      par_cs_n = 1'b1;
   endtask

   task automatic ser(input logic rd, input logic [7:0] a, input int n);
      @(negedge ref_clk);
      host.frame(rd, a, n);
   endtask

   task automatic ser_wr1(input logic [7:0] a, d);
      host.frame_data[0] = d;
      ser(1'b0, a, 1);
   endtask

   // Main sequence: parallel mode first, then serial mode
   initial begin
      nrst         = 1'b0;
      strap        = 1'b0;
      par_cs_n     = 1'b1;
      ale          = 1'b0;
      wr_n         = 1'b1;
      rd_n         = 1'b1;
      tim          = 1'b0;
      msg_event    = 1'b0;
      host_bus     = 8'h00;
      err_count    = 0;
      total_checks = 0;
      do_reset(1'b0);
      `CHK(ser_mode, 1'b0)
      `CHK({init_bit, hold_bit, join_bit}, 3'b110)
      par_wr(8'h20, 8'h5a, 1'b0);
      par_wr(8'h21, 8'ha5, 1'b0);
      par_rd(8'h20);
      `CHK(rd_data, 8'h5a)
      par_rd(8'h21);
      `CHK(rd_data, 8'ha5)
      par_rd(`CCHP_SETUP_ADDR);
      `CHK(rd_data, `CCHP_SETUP_RST)
      // Deselected strobes and serial frames must leave the byte alone
      par_wr(8'h20, 8'h11, 1'b1);
      ser_wr1(8'h20, 8'h22);
      par_rd(8'h20);
      `CHK(rd_data, 8'h5a)
      msg_event = 1'b1;
      repeat (2) @(negedge ref_clk);
      `CHK(irq_n, 1'b0)
      msg_event = 1'b0;
      repeat (2) @(negedge ref_clk);
      `CHK(irq_n, 1'b1)
      do_reset(1'b1);
      `CHK(ser_mode, 1'b1)
      for (int t = 0; t < 2; t++) begin
         @(negedge ref_clk);
         tim = t[0];
         ser_wr1(8'h40 | t[7:0], 8'hc3 ^ t[7:0]);
         ser(1'b1, 8'h40 | t[7:0], 1);
         `CHK(host.frame_data[0], 8'hc3 ^ t[7:0])
      end
      // Without decrement every data byte lands on the same address
      host.frame_data = '{8'h01, 8'h02, 8'h03, 8'h04};
      ser(1'b0, 8'h50, 2);
      ser(1'b1, 8'h50, 1);
      `CHK(host.frame_data[0], 8'h02)
      ser_wr1(`CCHP_SETUP_ADDR, 8'hff);
      ser(1'b1, `CCHP_SETUP_ADDR, 1);
      `CHK(host.frame_data[0], 8'h07)
      `CHK({init_bit, hold_bit, join_bit}, 3'b110)
      ser_wr1(`CCHP_SETUP_ADDR, 8'h04);
      ser(1'b1, `CCHP_SETUP_ADDR, 1);
      `CHK(host.frame_data[0], 8'h84)
      `CHK({init_bit, hold_bit, join_bit}, 3'b001)
      host.frame_data = '{8'h11, 8'h22, 8'h33, 8'h44};
      ser(1'b0, 8'h30, 3);
      ser(1'b1, 8'h30, 3);
      for (int k = 0; k < 3; k++) begin
         `CHK(host.frame_data[k], 8'h11 * (k[7:0] + 8'h01))
      end
      @(negedge ref_clk);
      tim = 1'b0;
      ser(1'b1, 8'h2f, 2);
      `CHK(host.frame_data[0], 8'h22)
      `CHK(host.frame_data[1], 8'h33)
      wrap_up();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #1000000;
      err_count++;
      wrap_up();
   end
endmodule // cchp_top_bench

bind cchp_top cchp_top_monitor mon (
   .ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
   .interface_select_in(interface_select_in), .cs_n_in(cs_n_in),
   .rd_n_in(rd_n_in), .sclk_in(sclk_in),
   .output_edge_select_in(output_edge_select_in),
   .msg_event_in(msg_event_in),
   .muxed_bus_lines_oe_n_out(muxed_bus_lines_oe_n_out),
   .serial_data_out(serial_data_out), .irq_n_out(irq_n_out),
   .init_mode_bit_out(init_mode_bit_out),
   .soft_hold_bit_out(soft_hold_bit_out),
   .bus_join_out(bus_join_out), .serial_mode_out(serial_mode_out));
